// ==== hw/sbp_bank_ctl.sv ====
// Burst engine with bank open/close tracking for an eight-bank DDR array.
// Assumes the controller keeps its own spacing rules; inputs are already
// synchronous to clk, and each clock carries two data words.
`default_nettype none
module sbp_bank_ctl (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic cs_n,
   input wire logic [9:0] ca_rise,
   input wire logic [9:0] ca_fall,
   input wire logic [31:0] wr_data,
   input wire logic [3:0] write_byte_mask,
   input wire logic [4:0] burst_length,
   input wire logic [3:0] read_latency,
   input wire logic [3:0] write_latency,
   input wire logic [3:0] rtp_cycles,
   output logic [31:0] rd_data,
   output logic rd_valid,
   output logic [7:0] bank_open,
   output logic burst_busy,
   output logic auto_close_evt
);
   // Reset release through two flops
   logic rst_s1_q;
   logic rst_n_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // Command decode for the current rising edge
   sbp_pkg::sbp_cmd_e cmd;
   logic [2:0] cmd_bank;
   logic all_bank_flag;
   logic auto_close_bit;
   logic [3:0] cmd_grp;

   assign cmd = sbp_pkg::cmd_decode(cs_n, ca_rise[3:0]);
   assign cmd_bank = ca_rise[sbp_pkg::BANK_SEL_LSB +: sbp_pkg::BANK_W];
   assign all_bank_flag = ca_rise[sbp_pkg::ALL_BANK_POS];
   assign auto_close_bit = ca_fall[sbp_pkg::AUTO_CLOSE_POS];
   assign cmd_grp = ca_fall[sbp_pkg::GRP_LSB +: sbp_pkg::GRP_W];

   // Burst state
   sbp_pkg::sbp_burst_e st_q;
   logic [5:0] since_q;
   logic [3:0] half_bl_q;
   logic ap_q;
   logic [2:0] bank_q;
   logic [3:0] grp_q;
   logic bst_used_q;

   logic [5:0] wl6;
   logic [5:0] rl6;
   logic [5:0] hb6;
   logic [5:0] wr_close_at;
   logic [5:0] rd_close_at;
   logic [5:0] rd_end_at;
   logic [5:0] end_at;
   logic bst_ok;
   logic new_burst;
   logic ap_fire;

   assign wl6 = {2'h0, write_latency};
   assign rl6 = {2'h0, read_latency};
   assign hb6 = {2'h0, half_bl_q};
   assign new_burst = (cmd == sbp_pkg::CMD_RD) || (cmd == sbp_pkg::CMD_WR);

   // Close and finish points, measured in cycles after the command
   assign wr_close_at = wl6 + hb6 + sbp_pkg::WR_CLOSE_GAP;
   assign rd_close_at = sbp_pkg::rd_close_point(half_bl_q,
                                                rtp_cycles);
   assign rd_end_at = ((rl6 + hb6) > rd_close_at) ? (rl6 + hb6)
                                                  : rd_close_at;
   assign end_at = (st_q == sbp_pkg::BURST_WR) ? wr_close_at : rd_end_at;

   // A stop counts only inside a live burst and only once; the controller
   // is trusted to place it on an even cycle
   assign bst_ok = (cmd == sbp_pkg::CMD_BST) && (st_q != sbp_pkg::BURST_IDLE)
                   && !bst_used_q && (since_q < hb6);

   // Auto-close strobe at the proper point of the most recent burst
   always_comb begin
      ap_fire = 1'b0;
      if (ap_q && st_q == sbp_pkg::BURST_WR) begin
         ap_fire = (since_q == wr_close_at);
      end else if (ap_q && st_q == sbp_pkg::BURST_RD) begin
         ap_fire = (since_q == rd_close_at);
      end
   end

   // Burst tracker; a new read or write restarts it, while a stop only
   // shrinks the length, so one counter serves both directions
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q <= sbp_pkg::BURST_IDLE;
         since_q <= 6'h00;
         half_bl_q <= 4'h0;
         ap_q <= 1'b0;
         bank_q <= 3'h0;
         grp_q <= 4'h0;
         bst_used_q <= 1'b0;
      end else if (ce) begin
         if (new_burst) begin
            st_q <= (cmd == sbp_pkg::CMD_WR) ? sbp_pkg::BURST_WR
                                             : sbp_pkg::BURST_RD;
            since_q <= 6'h01;
            half_bl_q <= burst_length[4:1];
            ap_q <= auto_close_bit;
            bank_q <= cmd_bank;
            grp_q <= cmd_grp;
            bst_used_q <= 1'b0;
         end else begin
            case (st_q)
               sbp_pkg::BURST_IDLE: begin
                  since_q <= 6'h00;
               end
               sbp_pkg::BURST_RD, sbp_pkg::BURST_WR: begin
                  since_q <= since_q + 6'h01;
                  if (bst_ok) begin
                     half_bl_q <= since_q[3:0];
                     bst_used_q <= 1'b1;
                  end
                  if (since_q >= end_at) begin
                     st_q <= sbp_pkg::BURST_IDLE;
                     ap_q <= 1'b0;
                  end
               end
               default: begin
                  st_q <= sbp_pkg::BURST_IDLE;
               end
            endcase
         end
      end
   end

   // Per-bank open state; activate wins over a close in the same cycle
   logic [7:0] bank_open_q;
   logic [7:0] open_set;
   logic [7:0] open_clr;

   always_comb begin
      open_set = 8'h00;
      open_clr = 8'h00;
      if (cmd == sbp_pkg::CMD_ACT) begin
         open_set = sbp_pkg::bank_onehot(cmd_bank);
      end
      if (cmd == sbp_pkg::CMD_PRE) begin
         open_clr = all_bank_flag ? 8'hff
                                  : sbp_pkg::bank_onehot(cmd_bank);
      end
      if (ap_fire) begin
         open_clr = open_clr | sbp_pkg::bank_onehot(bank_q);
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bank_open_q <= sbp_pkg::BANK_OPEN_RST;
      end else if (ce) begin
         bank_open_q <= (bank_open_q & ~open_clr) | open_set;
      end
   end

   // Memory carrier
   sbp_mem_if mif ();

   sbp_mem u_mem (
      .clk(clk),
      .rst_n(rst_n_q),
      .ce(ce),
      .m(mif)
   );

   // Write path: data index counts from the write latency point; the
   // shrunken length cuts sampling at latency plus the stop cycle
   logic [5:0] wd;
   logic wr_beat;
   logic [31:0] wbuf_q;
   logic [3:0] mbuf_q;

   assign wd = since_q - wl6;
   assign wr_beat = (st_q == sbp_pkg::BURST_WR) && (since_q >= wl6)
                    && (wd < hb6);

   // Even beat pair is parked, mask alongside data on the same strobe
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wbuf_q <= 32'h00000000;
         mbuf_q <= 4'h0;
      end else if (ce && wr_beat && !wd[0]) begin
         wbuf_q <= wr_data;
         mbuf_q <= write_byte_mask;
      end
   end

   // Whole group goes to the array on the odd cycle only
   assign mif.we = wr_beat && wd[0];
   assign mif.waddr = {bank_q, 4'(grp_q + wd[4:1])};
   assign mif.wdata = {wr_data, wbuf_q};
   assign mif.wbe = ~{write_byte_mask, mbuf_q};

   // Read path: array read issued two cycles before the data cycle so the
   // output itself can come from a flop; needs a read latency of three+
   logic [6:0] q7;
   logic rd_in_range;
   logic [5:0] q;
   logic [31:0] rd_data_q;
   logic [31:0] rhold_q;
   logic rd_valid_q;

   assign q7 = {1'b0, since_q} + sbp_pkg::RD_ISSUE_LEAD - {1'b0, rl6};
   assign q = q7[5:0];
   assign rd_in_range = ({1'b0, since_q} + sbp_pkg::RD_ISSUE_LEAD)
                        >= {1'b0, rl6};
   assign mif.raddr = {bank_q, 4'(grp_q + q[4:1])};

   // Output words; a stop shrinks the window seen here
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_data_q <= 32'h00000000;
         rhold_q <= 32'h00000000;
         rd_valid_q <= 1'b0;
      end else if (ce) begin
         rd_valid_q <= 1'b0;
         if (st_q == sbp_pkg::BURST_RD && rd_in_range && q >= 6'h01
             && q <= hb6) begin
            rd_valid_q <= 1'b1;
            if (q[0]) begin
               rd_data_q <= mif.rdata[31:0];
               rhold_q <= mif.rdata[63:32];
            end else begin
               rd_data_q <= rhold_q;
            end
         end
      end
   end

   // Outputs
   assign rd_data = rd_data_q;
   assign rd_valid = rd_valid_q;
   assign bank_open = bank_open_q;
   assign burst_busy = (st_q != sbp_pkg::BURST_IDLE);
   assign auto_close_evt = ap_fire && ce;
endmodule
`default_nettype wire

// ==== hw/sbp_mem.sv ====
// Prefetch-group array: one four-word group per entry, byte write enables.
// Assumes the caller presents only complete groups; read data registered.
`default_nettype none
module sbp_mem (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   sbp_mem_if.mem m
);
   localparam int unsigned DEPTH = 1 << sbp_pkg::ADDR_W;
   localparam int unsigned NBE = sbp_pkg::GROUP_W / 8;

   logic [sbp_pkg::GROUP_W-1:0] arr [DEPTH];
   logic [sbp_pkg::GROUP_W-1:0] rdata_q;

   // Array carries no reset, so it maps onto plain RAM
   always_ff @(posedge clk) begin
      if (ce && m.we) begin
         for (int i = 0; i < NBE; i++) begin
            if (m.wbe[i]) begin
               arr[m.waddr][8*i +: 8] <= m.wdata[8*i +: 8];
            end
         end
      end
   end

   // Registered read port, one cycle of latency
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (ce) begin
         rdata_q <= arr[m.raddr];
      end
   end

   assign m.rdata = rdata_q;
endmodule
`default_nettype wire

// ==== hw/sbp_mem_if.sv ====
// Carrier between the burst engine and its array memory.
// Assumes one clock; write and read addresses are independent.
`default_nettype none
interface sbp_mem_if;
   logic we;
   logic [sbp_pkg::ADDR_W-1:0] waddr;
   logic [sbp_pkg::GROUP_W-1:0] wdata;
   logic [sbp_pkg::GROUP_W/8-1:0] wbe;
   logic [sbp_pkg::ADDR_W-1:0] raddr;
   logic [sbp_pkg::GROUP_W-1:0] rdata;
   modport ctl (output we, output waddr, output wdata, output wbe,
                output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input wbe,
                input raddr, output rdata);
endinterface
`default_nettype wire

// ==== hw/sbp_pkg.sv ====
// Constants, types and decode helpers for the bank close / burst stop block.
// Assumes command/address fields arrive already split into rising and
// falling halves, each synchronous to the core clock.
`default_nettype none
package sbp_pkg;
   // Geometry
   localparam int unsigned BANKS = 8;
   localparam int unsigned BANK_W = 3;
   localparam int unsigned GRP_W = 4;
   localparam int unsigned ADDR_W = BANK_W + GRP_W;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned BYTES_PER_CLK = 4;
   localparam int unsigned GROUP_W = 4 * WORD_W;
   localparam int unsigned CNT_W = 6;

   // Field positions on the rising and falling command halves
   localparam int unsigned ALL_BANK_POS = 4;
   localparam int unsigned BANK_SEL_LSB = 7;
   localparam int unsigned AUTO_CLOSE_POS = 0;
   localparam int unsigned GRP_LSB = 1;

   // Reset values
   localparam logic [BANKS-1:0] BANK_OPEN_RST = 8'h00;

   // Timing counts, in clock cycles
   localparam logic [CNT_W-1:0] WR_CLOSE_GAP = 6'h02;
   localparam logic [CNT_W-1:0] RTP_START_BACK = 6'h02;
   localparam logic [CNT_W:0] RD_ISSUE_LEAD = 7'h02;

   typedef enum logic [2:0] {
      CMD_NONE, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_BST
   } sbp_cmd_e;

   typedef enum logic [1:0] {
      BURST_IDLE, BURST_RD, BURST_WR
   } sbp_burst_e;

   // Decode one rising-edge command slot
   function automatic sbp_cmd_e cmd_decode(input logic cs_n,
                                           input logic [3:0] ca);
      cmd_decode = CMD_NONE;
      if (!cs_n) begin
         casez (ca)
            4'b??10: cmd_decode = CMD_ACT;
            4'b?101: cmd_decode = CMD_RD;
            4'b?001: cmd_decode = CMD_WR;
            4'b1011: cmd_decode = CMD_PRE;
            4'b0011: cmd_decode = CMD_BST;
            default: cmd_decode = CMD_NONE;
         endcase
      end
   endfunction

   function automatic logic [BANKS-1:0] bank_onehot(
         input logic [BANK_W-1:0] b);
      bank_onehot = 8'h01 << b;
   endfunction

   // Auto-close point of a read: max(half length, half length - 2 + rtp)
   function automatic logic [CNT_W-1:0] rd_close_point(
         input logic [3:0] half_bl, input logic [3:0] rtp);
      logic [CNT_W-1:0] a;
      logic [CNT_W-1:0] b;
      a = {2'h0, half_bl};
      b = a + {2'h0, rtp} - RTP_START_BACK;
      rd_close_point = (b > a) ? b : a;
   endfunction
endpackage
`default_nettype wire

// ==== sim/sbp_bank_ctl_properties.sv ====
// Port-level assertions for the bank close / burst stop block.
// Assumes control settings stay fixed while a burst is tracked.
`default_nettype none
module sbp_bank_ctl_properties (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic cs_n,
   input wire logic [9:0] ca_rise,
   input wire logic [9:0] ca_fall,
   input wire logic [4:0] burst_length,
   input wire logic [3:0] read_latency,
   input wire logic [3:0] write_latency,
   input wire logic [3:0] rtp_cycles,
   input wire logic rd_valid,
   input wire logic [7:0] bank_open,
   input wire logic auto_close_evt
);
   logic [1:0] up_q;
   logic [5:0] cnt_q;
   logic [3:0] eff_q;
   logic [2:0] bank_q;
   logic rd_q, ap_q, trk_q, stop_q, go, is_rw, in_rd;
   int pt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Command taken only once the design's reset copy has let go
   assign go = ce && !cs_n && up_q == 2'h3;
   assign is_rw = go && ca_rise[1:0] == 2'b01;
   assign in_rd = int'(cnt_q) >= int'(read_latency)
      && int'(cnt_q) < int'(read_latency) + int'(eff_q);
   assign pt = !rd_q ? int'(write_latency) + int'(eff_q) + 2 :
      (rtp_cycles > 4'h2 ? int'(eff_q) + int'(rtp_cycles) - 2 : int'(eff_q));
   // Three edges cover the two-flop reset release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         up_q <= 2'h0;
      end else if (up_q != 2'h3) begin
         up_q <= up_q + 2'h1;
      end
   end
   // Shadow of the burst: cycle count, kind and effective half length
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 6'h00;
         eff_q <= 4'h0;
         bank_q <= 3'h0;
         rd_q <= 1'b0;
         ap_q <= 1'b0;
         trk_q <= 1'b0;
         stop_q <= 1'b0;
      end else if (is_rw) begin
         cnt_q <= 6'h01;
         eff_q <= burst_length[4:1];
         bank_q <= ca_rise[9:7];
         rd_q <= ca_rise[2];
         ap_q <= ca_fall[0];
         trk_q <= 1'b1;
         stop_q <= 1'b0;
      end else if (ce) begin
         if (cnt_q != 6'h3f) begin
            cnt_q <= cnt_q + 6'h01;
         end
         if (go && ca_rise[3:0] == 4'h3 && trk_q && !stop_q
             && cnt_q < {2'h0, eff_q}) begin
            eff_q <= cnt_q[3:0];
            stop_q <= 1'b1;
         end
      end
   end
   property p_act_open;
      go && ca_rise[1:0] == 2'b10 |=> bank_open[$past(ca_rise[9:7])];
   endproperty
   a_act_open: assert property (p_act_open)
      else $error("activate left bank closed");
   property p_pre_one;
      go && ca_rise[3:0] == 4'hb && !ca_rise[4] && !auto_close_evt |=>
         bank_open == ($past(bank_open) & ~(8'h01 << $past(ca_rise[9:7])));
   endproperty
   a_pre_one: assert property (p_pre_one)
      else $error("single bank close wrong");
   property p_pre_all;
      go && ca_rise[3:0] == 4'hb && ca_rise[4] |=> bank_open == 8'h00;
   endproperty
   a_pre_all: assert property (p_pre_all)
      else $error("all bank close left a bank open");
   property p_rd_win;
      trk_q && rd_q |-> rd_valid == in_rd;
   endproperty
   a_rd_win: assert property (p_rd_win)
      else $error("read data window wrong");
   property p_ac_due;
      trk_q && ap_q && int'(cnt_q) == pt |-> auto_close_evt;
   endproperty
   a_ac_due: assert property (p_ac_due)
      else $error("auto close missing at its point");
   property p_ac_only;
      auto_close_evt |-> trk_q && ap_q && int'(cnt_q) == pt;
   endproperty
   a_ac_only: assert property (p_ac_only)
      else $error("auto close at wrong time");
   property p_ac_shut;
      auto_close_evt |=> !bank_open[$past(bank_q)];
   endproperty
   a_ac_shut: assert property (p_ac_shut)
      else $error("auto close left bank open");
   property p_bank_keep;
      !go && !auto_close_evt |=> $stable(bank_open);
   endproperty
   a_bank_keep: assert property (p_bank_keep)
      else $error("bank state moved with no cause");
endmodule
bind sbp_bank_ctl sbp_bank_ctl_properties u_props (.clk(clk), .nrst(nrst),
   .ce(ce), .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall),
   .burst_length(burst_length), .read_latency(read_latency),
   .write_latency(write_latency), .rtp_cycles(rtp_cycles),
   .rd_valid(rd_valid), .bank_open(bank_open),
   .auto_close_evt(auto_close_evt));
`default_nettype wire

// ==== sim/sbp_ctl_model.sv ====
// Controller model: command/address, write data and byte masks.
// Assumes the caller sizes the idle gap after each command.
`default_nettype none
module sbp_ctl_model (
   input wire logic clk,
   input wire logic [4:0] burst_length,
   input wire logic [3:0] write_latency,
   output var logic cs_n,
   output var logic [9:0] ca_rise,
   output var logic [9:0] ca_fall,
   output var logic [31:0] wr_data,
   output var logic [3:0] write_byte_mask
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus at time zero
   initial begin
      cs_n = 1'b1;
      ca_rise = 10'h000;
      ca_fall = 10'h000;
      wr_data = 32'h00000000;
      write_byte_mask = 4'h0;
   end
   // Command at cycle 0, optional stop at cycle k, idle up to cycle n;
   // released lines toggle so stale values cannot pass as data
   task automatic run(input logic [3:0] op, input logic [2:0] bank,
         input logic ab, input logic ap, input int k,
         input logic [31:0] base, input int mb, input int n);
      int wl;
      int hl;
      wl = int'(write_latency);
      hl = (k > 0) ? k : int'(burst_length[4:1]);
      // Gap covers row, recovery and precharge times
      for (int c = 0; c <= n; c++) begin
         @(posedge clk);
         #1;
         cs_n = !(c == 0 || (k > 0 && c == k));
         ca_rise = (c == 0) ? {bank, 2'h0, ab, op} :
            ((k > 0 && c == k) ? 10'h003 : ~ca_rise);
         ca_fall = (c == 0) ? {9'h000, ap} : ~ca_fall;
         if (op[2:0] == 3'b001 && c >= wl && c < wl + hl) begin
            wr_data = base + 32'(c - wl);
            write_byte_mask = (c - wl == mb) ? 4'h2 : 4'h0;
         end else begin
            wr_data = ~wr_data;
            write_byte_mask = ~write_byte_mask;
         end
      end
   endtask
endmodule
`default_nettype wire

// ==== sim/test_sbp_bank_ctl.sv ====
// Bench for the bank close / burst stop block.
// Assumes the controller model drives the command side.
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   fail_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_sbp_bank_ctl;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] A = 32'ha5a5a5a0;
   localparam logic [31:0] B = 32'h3c3c3c30;
   logic clk, nrst, ce, cs_n, rd_valid, burst_busy, auto_close_evt;
   logic [9:0] ca_rise, ca_fall;
   logic [31:0] wr_data, rd_data;
   logic [3:0] write_byte_mask, read_latency, write_latency, rtp_cycles;
   logic [4:0] burst_length;
   logic [7:0] bank_open;
   logic [31:0] rq[$];
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int t0, ac_at, nb;
   sbp_bank_ctl DUT (.clk(clk), .nrst(nrst), .ce(ce), .cs_n(cs_n),
      .ca_rise(ca_rise), .ca_fall(ca_fall), .wr_data(wr_data),
      .write_byte_mask(write_byte_mask), .burst_length(burst_length),
      .read_latency(read_latency), .write_latency(write_latency),
      .rtp_cycles(rtp_cycles), .rd_data(rd_data), .rd_valid(rd_valid),
      .bank_open(bank_open), .burst_busy(burst_busy),
      .auto_close_evt(auto_close_evt));
   sbp_ctl_model u_mdl (.clk(clk), .burst_length(burst_length),
      .write_latency(write_latency), .cs_n(cs_n), .ca_rise(ca_rise),
      .ca_fall(ca_fall), .wr_data(wr_data),
      .write_byte_mask(write_byte_mask));
   // 50 ns clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Cycle count, read words and auto-close cycle, all edge sampled
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (auto_close_evt === 1'b1) ac_at <= cyc - t0;
      if (burst_busy === 1'b1) nb <= nb + 1;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // One operation; cycle 0 of it is edge t0
   task automatic go(input logic [3:0] op, input logic [2:0] b,
         input logic ab, input logic ap, input int k,
         input logic [31:0] base, input int mb, input int n);
      rq.delete();
      ac_at = -1;
      nb = 0;
      t0 = cyc + 1;
      u_mdl.run(op, b, ab, ap, k, base, mb, n);
   endtask
   // Hang guard, far above the roughly 140 cycles needed
   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      burst_length = 5'h08;
      read_latency = 4'h3;
      write_latency = 4'h1;
      rtp_cycles = 4'h3;
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      `CHK("bank reset", 8'h00, bank_open)
      for (int b = 0; b < 8; b++) go(4'h2, b[2:0], 0, 0, 0, A, -1, 1);
      `CHK("open all", 8'hff, bank_open)
      go(4'hb, 3'h3, 1'b0, 0, 0, A, -1, 2);
      `CHK("close one", 8'hf7, bank_open)
      go(4'hb, 3'h3, 1'b1, 0, 0, A, -1, 4);
      `CHK("close all", 8'h00, bank_open)
      go(4'h2, 3'h2, 0, 0, 0, A, -1, 1);
      go(4'h2, 3'h6, 0, 0, 0, A, -1, 1);
      ce = 1'b0;
      go(4'h2, 3'h5, 0, 0, 0, A, -1, 1);
      ce = 1'b1;
      `CHK("frozen", 8'h44, bank_open)
      go(4'h1, 3'h2, 0, 0, 0, A, -1, 8);
      `CHK("wr busy", 7, nb)
      `CHK("wr idle", 1'b0, burst_busy)
      go(4'h1, 3'h2, 0, 0, 2, B, 0, 8);
      `CHK("stop busy", 5, nb)
      `CHK("open after write", 8'h44, bank_open)
      go(4'h5, 3'h2, 0, 0, 0, A, -1, 10);
      `CHK("rd busy", 7, nb)
      `CHK("rd count", 4, rq.size())
      `CHK("rd0", {B[31:16], A[15:8], B[7:0]}, rq[0])
      `CHK("rd1", B + 32'h1, rq[1])
      `CHK("rd2", A + 32'h2, rq[2])
      `CHK("rd3", A + 32'h3, rq[3])
      `CHK("no close", -1, ac_at)
      go(4'h5, 3'h2, 0, 0, 2, A, -1, 10);
      `CHK("stop count", 2, rq.size())
      for (int r = 1; r < 5; r += 3) begin
         rtp_cycles = r[3:0];
         go(4'h5, 3'h2, 0, 1, 0, A, -1, 12);
         `CHK("rd close at", (r > 2) ? 2 + r : 4, ac_at)
         `CHK("rd closed", 8'h40, bank_open)
         go(4'h2, 3'h2, 0, 0, 0, A, -1, 1);
      end
      burst_length = 5'h04;
      for (int w = 1; w < 4; w += 2) begin
         write_latency = w[3:0];
         go(4'h1, 3'h2, 0, 1, 0, A, -1, 12);
         `CHK("wr close at", w + 4, ac_at)
         `CHK("wr closed", 8'h40, bank_open)
         go(4'h2, 3'h2, 0, 0, 0, A, -1, 1);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
